// ==== bcm_defs.vh ====
// constants for the bit and carry manipulation unit
`ifndef BCM_DEFS_VH
`define BCM_DEFS_VH
// operation codes
`define BCM_OP_LOAD 3'h0
`define BCM_OP_ILOAD 3'h1
`define BCM_OP_STORE 3'h2
`define BCM_OP_ISTORE 3'h3
`define BCM_OP_AND 3'h4
// operand modes
`define BCM_MODE_REG 2'h0
`define BCM_MODE_IND 2'h1
`define BCM_MODE_ABS 2'h2
// condition code field positions
`define BCM_CCR_I 7
`define BCM_CCR_H 5
`define BCM_CCR_N 3
`define BCM_CCR_Z 2
`define BCM_CCR_V 1
`define BCM_CCR_C 0
`define BCM_CCR_RST 8'h80
// execution states per form
`define BCM_ST_REG 4'h2
`define BCM_ST_MEM_LD 4'h6
`define BCM_ST_MEM_ST 4'h8
// encoding lengths in bytes
`define BCM_LEN_REG 3'h2
`define BCM_LEN_MEM 3'h4
// steps inside a memory form
`define BCM_STEP_ADDR 4'h1
`define BCM_STEP_DATA 4'h3
// upper bits of a short absolute address
`define BCM_ABS_PAGE 16'hFFFF
`endif

// ==== bcm_regfile.v ====
// general register file: eight 32-bit words, byte writable
`timescale 1ns/1ps
`default_nettype none
module bcm_regfile (
	input wire clk,
	input wire [2:0] rdIdx,
	output reg [31:0] rdData_ff,
	input wire [2:0] wrIdx,
	input wire [3:0] wrByteEn,
	input wire [31:0] wrData
);
	reg [31:0] mem [0:7];
	genvar g;
	generate
		for (g = 0; g < 4; g = g + 1) begin : gLane
			always @(posedge clk) begin
				if (wrByteEn[g]) begin
					mem[wrIdx][g*8 +: 8] <= wrData[g*8 +: 8];
				end
			end
		end
	endgenerate
	always @(posedge clk) begin
		rdData_ff <= mem[rdIdx];
	end
endmodule // bcm_regfile
`default_nettype wire

// ==== bcm_unit.v ====
// bit and carry manipulation datapath with its register file
`timescale 1ns/1ps
`default_nettype none
`include "bcm_defs.vh"
module bcm_unit (
	input wire clk,
	input wire arst_n,
	input wire start,
	input wire [2:0] opSel,
	input wire [1:0] modeSel,
	input wire [2:0] bitPos,
	input wire [3:0] regSel,
	input wire [7:0] absAddr,
	input wire ccrLoad,
	input wire [7:0] ccrIn,
	input wire extWrEn,
	input wire [2:0] extWrIdx,
	input wire [31:0] extWrData,
	input wire [2:0] extRdIdx,
	output wire [31:0] regRdData,
	input wire [7:0] memRdData,
	output reg busy_ff,
	output reg done_ff,
	output reg [7:0] ccr_ff,
	output reg memRd_ff,
	output reg memWr_ff,
	output reg [23:0] memAddr_ff,
	output reg [7:0] memWrData_ff,
	output reg [2:0] instLen_ff
);
	localparam IDLE = 1'b0;
	localparam RUN = 1'b1;
	////////////////////////////////////////////////////////////////////////
	// reset release
	reg rstSync1_ff;
	reg rstSync2_ff;
	wire rstN;
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rstSync1_ff <= 1'b0;
			rstSync2_ff <= 1'b0;
		end else begin
			rstSync1_ff <= 1'b1;
			rstSync2_ff <= rstSync1_ff;
		end
	end
	assign rstN = rstSync2_ff;
	////////////////////////////////////////////////////////////////////////
	// captured instruction
	reg state_ff;
	reg [3:0] step_ff;
	reg [3:0] last_ff;
	reg [2:0] op_ff;
	reg [1:0] mode_ff;
	reg [2:0] pos_ff;
	reg [3:0] sel_ff;
	reg [7:0] abs_ff;
	reg [7:0] opnd_ff;
	wire isStore;
	wire isMem;
	wire [3:0] total;
	assign isStore = (opSel == `BCM_OP_STORE) || (opSel == `BCM_OP_ISTORE);
	assign isMem = (modeSel == `BCM_MODE_IND) || (modeSel == `BCM_MODE_ABS);
	assign total = !isMem ? `BCM_ST_REG :
		(isStore ? `BCM_ST_MEM_ST : `BCM_ST_MEM_LD);
	////////////////////////////////////////////////////////////////////////
	// register file access
	wire [2:0] rfRdIdx;
	wire [31:0] rfRdData;
	reg [2:0] rfWrIdx;
	reg [3:0] rfWrEn;
	reg [31:0] rfWrData;
	wire takeStart;
	assign takeStart = (state_ff == IDLE) && start;
	assign rfRdIdx = takeStart ? regSel[2:0] :
		(busy_ff ? sel_ff[2:0] : extRdIdx);
	assign regRdData = rfRdData;
	bcm_regfile uRegs (
		.clk(clk),
		.rdIdx(rfRdIdx),
		.rdData_ff(rfRdData),
		.wrIdx(rfWrIdx),
		.wrByteEn(rfWrEn),
		.wrData(rfWrData)
	);
	// byte register: codes 0-7 high half, 8-F low half
	wire [7:0] regByte;
	assign regByte = sel_ff[3] ? rfRdData[7:0] : rfRdData[15:8];
	////////////////////////////////////////////////////////////////////////
	// bit arithmetic
	wire lastStep;
	wire [7:0] srcByte;
	wire bitVal;
	wire carry;
	wire putBit;
	reg nxtCarry;
	wire [7:0] newByte;
	wire [7:0] posHot;
	wire opStore;
	wire regStore;
	wire memStore;
	assign lastStep = (state_ff == RUN) && (step_ff == last_ff);
	assign srcByte = (mode_ff == `BCM_MODE_REG) ? regByte : opnd_ff;
	assign bitVal = srcByte[pos_ff];
	assign carry = ccr_ff[`BCM_CCR_C];
	assign putBit = (op_ff == `BCM_OP_ISTORE) ? ~carry : carry;
	// store decode
	assign opStore = (op_ff == `BCM_OP_STORE) || (op_ff == `BCM_OP_ISTORE);
	assign regStore = lastStep && (mode_ff == `BCM_MODE_REG) && opStore;
	assign memStore = (mode_ff != `BCM_MODE_REG) && opStore;
	assign posHot = 8'h01 << pos_ff;
	////////////////////////////////////////////////////////////////////////
	// bit insertion
	genvar gb;
	generate
		for (gb = 0; gb < 8; gb = gb + 1) begin : gBit
			assign newByte[gb] = posHot[gb] ? putBit : srcByte[gb];
		end
	endgenerate
	always @* begin
		case (op_ff)
			`BCM_OP_LOAD: nxtCarry = bitVal;
			`BCM_OP_ILOAD: nxtCarry = ~bitVal;
			`BCM_OP_AND: nxtCarry = carry & bitVal;
			default: nxtCarry = carry;
		endcase
	end
	always @* begin
		rfWrIdx = extWrIdx;
		rfWrEn = extWrEn ? 4'hF : 4'h0;
		rfWrData = extWrData;
		if (regStore) begin
			rfWrIdx = sel_ff[2:0];
			rfWrEn = sel_ff[3] ? 4'h1 : 4'h2;
			rfWrData = {16'h0000, newByte, newByte};
		end
	end
	////////////////////////////////////////////////////////////////////////
	// sequencer
	always @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			state_ff <= IDLE;
			step_ff <= 4'h0;
			last_ff <= 4'h0;
			op_ff <= 3'h0;
			mode_ff <= 2'h0;
			pos_ff <= 3'h0;
			sel_ff <= 4'h0;
			abs_ff <= 8'h00;
			opnd_ff <= 8'h00;
			busy_ff <= 1'b0;
			done_ff <= 1'b0;
			ccr_ff <= `BCM_CCR_RST;
			memRd_ff <= 1'b0;
			memWr_ff <= 1'b0;
			memAddr_ff <= 24'h000000;
			memWrData_ff <= 8'h00;
			instLen_ff <= 3'h0;
		end else begin
			done_ff <= 1'b0;
			memRd_ff <= 1'b0;
			memWr_ff <= 1'b0;
			if (ccrLoad && (state_ff == IDLE)) begin
				ccr_ff <= ccrIn;
			end
			case (state_ff)
				IDLE: begin
					if (start) begin
						state_ff <= RUN;
						busy_ff <= 1'b1;
						step_ff <= 4'h1;
						last_ff <= total - 4'h1;
						op_ff <= opSel;
						mode_ff <= isMem ? modeSel : `BCM_MODE_REG;
						pos_ff <= bitPos;
						sel_ff <= regSel;
						abs_ff <= absAddr;
						instLen_ff <= isMem ? `BCM_LEN_MEM : `BCM_LEN_REG;
					end
				end
				RUN: begin
					step_ff <= step_ff + 4'h1;
					if ((mode_ff != `BCM_MODE_REG) && (step_ff == `BCM_STEP_ADDR)) begin
						memRd_ff <= 1'b1;
						memAddr_ff <= (mode_ff == `BCM_MODE_IND) ? rfRdData[23:0] :
							{`BCM_ABS_PAGE, abs_ff};
					end
					if ((mode_ff != `BCM_MODE_REG) && (step_ff == `BCM_STEP_DATA)) begin
						opnd_ff <= memRdData;
					end
					if (lastStep) begin
						state_ff <= IDLE;
						busy_ff <= 1'b0;
						done_ff <= 1'b1;
						ccr_ff[`BCM_CCR_C] <= nxtCarry;
						if (memStore) begin
							memWr_ff <= 1'b1;
							memWrData_ff <= newByte;
						end
					end
				end
				default: begin
					state_ff <= IDLE;
					busy_ff <= 1'b0;
				end
			endcase
		end
	end
endmodule // bcm_unit
`default_nettype wire

// ==== bcm_unit_sva.sv ====
// assertions for the bit and carry unit
`timescale 1ns/1ps
`default_nettype none
module bcm_unit_sva (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic start,
	input wire logic [2:0] opSel,
	input wire logic [1:0] modeSel,
	input wire logic [7:0] absAddr,
	input wire logic busy_ff,
	input wire logic done_ff,
	input wire logic [7:0] ccr_ff,
	input wire logic memRd_ff,
	input wire logic memWr_ff,
	input wire logic [23:0] memAddr_ff
);
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);
	wire tk = start && !busy_ff && opSel <= 3'h4;
	wire mem = modeSel == 2'h1 || modeSel == 2'h2;
	wire st = opSel == 3'h2 || opSel == 3'h3;
	chk_reg_two: assert property (tk && !mem |-> ##1 busy_ff ##1 (done_ff && !busy_ff))
		else $error("register form not done in 2 states");
	chk_mem_ld_six: assert property (tk && mem && !st |-> ##1 busy_ff [*5] ##1 done_ff)
		else $error("memory load not done in 6 states");
	chk_mem_st_eight: assert property (tk && mem && st |-> ##8 (done_ff && memWr_ff))
		else $error("memory store not done in 8 states");
	chk_flags_kept: assert property (busy_ff |=> $stable(ccr_ff[7:1]))
		else $error("other flag changed");
	chk_store_keeps_c: assert property (tk && st |-> ##2 $stable(ccr_ff[0]))
		else $error("store changed carry");
	chk_mstore_keeps_c: assert property (tk && mem && st |-> ##8 $stable(ccr_ff[0]))
		else $error("memory store changed carry");
	chk_abs_addr: assert property (tk && modeSel == 2'h2 |-> ##2 (memRd_ff && memAddr_ff == {16'hFFFF, $past(absAddr, 2)}))
		else $error("short address read wrong");
	chk_wr_done: assert property (memWr_ff |-> done_ff)
		else $error("write outside last state");
	chk_rd_pulse: assert property (memRd_ff |=> !memRd_ff && busy_ff)
		else $error("read strobe not a pulse");
	cover property (tk && !mem && st);
	cover property (tk && modeSel == 2'h1 && opSel == 3'h4);
	cover property (memWr_ff);
	cover property (tk && modeSel == 2'h3);
endmodule // bcm_unit_sva
bind bcm_unit bcm_unit_sva chk_u (.*);
`default_nettype wire

// ==== bcm_mem_model.sv ====
// memory stage model answering byte reads and writes
`timescale 1ns/1ps
`default_nettype none
module bcm_mem_model (
	input wire logic clk,
	input wire logic memRd,
	input wire logic memWr,
	input wire logic [23:0] memAddr,
	input wire logic [7:0] memWrData,
	output var logic [7:0] memRdData
);
	logic [7:0] mem [256];
	logic [1:0] rdPipe = 2'h0;
	logic [7:0] junk = 8'h5A;
	always @(posedge clk) begin
		rdPipe <= {rdPipe[0], memRd};
		junk <= ~junk + 8'h01;
		if (memWr)
			mem[memAddr[7:0]] <= memWrData;
	end
	// byte only while sampled, garbage otherwise
	always_comb memRdData = |rdPipe ? mem[memAddr[7:0]] : junk;
endmodule // bcm_mem_model
`default_nettype wire

// ==== bcm_unit_tb.sv ====
// self-checking bench for the bit and carry unit
`timescale 1ns/1ps
`default_nettype none
`include "bcm_defs.vh"
module bcm_unit_tb;
	logic clk = '0, arst_n = '0, start = '0, ccrLoad = '0, extWrEn = '0;
	logic [2:0] opSel = '0, bitPos = '0, extWrIdx = '0, extRdIdx = '0;
	logic [1:0] modeSel = '0;
	logic [3:0] regSel = '0;
	logic [7:0] absAddr = '0, ccrIn = '0, memRdData, ccr_ff, memWrData_ff;
	logic [31:0] extWrData = '0, regRdData, rf [8];
	logic [7:0] sh [256];
	logic busy_ff, done_ff, memRd_ff, memWr_ff, c, m;
	logic [23:0] memAddr_ff;
	logic [2:0] instLen_ff;
	logic [7:0] a, b, nb;
	logic [19:0] e, exq [$];
	int fails = 0, checked = 0, cyc = 0;
	bcm_unit dut_u (
		.clk(clk), .arst_n(arst_n), .start(start), .opSel(opSel),
		.modeSel(modeSel), .bitPos(bitPos), .regSel(regSel),
		.absAddr(absAddr), .ccrLoad(ccrLoad), .ccrIn(ccrIn),
		.extWrEn(extWrEn), .extWrIdx(extWrIdx), .extWrData(extWrData),
		.extRdIdx(extRdIdx), .regRdData(regRdData), .memRdData(memRdData),
		.busy_ff(busy_ff), .done_ff(done_ff), .ccr_ff(ccr_ff),
		.memRd_ff(memRd_ff), .memWr_ff(memWr_ff), .memAddr_ff(memAddr_ff),
		.memWrData_ff(memWrData_ff), .instLen_ff(instLen_ff)
	);
	bcm_mem_model mdl_u (.clk, .memRd(memRd_ff), .memWr(memWr_ff),
		.memAddr(memAddr_ff), .memWrData(memWrData_ff), .memRdData);
	always #25 clk = ~clk;
	task automatic bad(input string m);
		fails++;
		$display("MISMATCH %0t %s", $time, m);
	endtask
	task automatic chkCcr(input logic [7:0] x);
		checked++;
		if (ccr_ff !== x) bad("flags");
	endtask
	task automatic chkWr(input logic en, input logic [7:0] x);
		checked++;
		if (memWr_ff !== en || (en && memWrData_ff !== x)) bad("store byte");
	endtask
	task automatic chkLen(input logic [2:0] x);
		checked++;
		if (instLen_ff !== x) bad("encoding length");
	endtask
	task automatic chkReg(input logic [31:0] x);
		checked++;
		if (regRdData !== x) bad("register word");
	endtask
	task automatic give_verdict;
		$display("checked %0d fails %0d", checked, fails);
		if (fails == 0 && checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc > 2000) begin
			bad("timeout");
			give_verdict;
		end else if (done_ff === 1'h1) begin
			if (exq.size() == 0) begin
				bad("unexpected done");
			end else begin
				e = exq.pop_front();
				chkCcr(e[7:0]);
				chkLen(e[19:17]);
				chkWr(e[16], e[15:8]);
			end
		end
	end
	initial begin
		void'($urandom(2549));
		for (int i = 0; i < 256; i++) begin
			sh[i] = 8'($urandom);
			mdl_u.mem[i] = sh[i];
		end
		repeat (3) @(posedge clk);
		arst_n <= 1'h1;
		repeat (3) @(posedge clk);
		chkCcr(`BCM_CCR_RST);
		for (int i = 0; i < 8; i++) begin
			@(posedge clk);
			rf[i] = $urandom;
			extWrEn <= 1'h1;
			extWrIdx <= i[2:0];
			extWrData <= rf[i];
		end
		for (int n = 0; n < 80; n++) begin
			@(posedge clk);
			extWrEn <= 1'h0;
			ccrLoad <= 1'h1;
			{bitPos, regSel, absAddr, ccrIn} <= 23'($urandom);
			opSel <= 3'($urandom);
			modeSel <= 2'($urandom);
			@(posedge clk);
			ccrLoad <= 1'h0;
			start <= 1'h1;
			m = modeSel == 2'h1 || modeSel == 2'h2;
			a = modeSel == 2'h2 ? absAddr : rf[regSel[2:0]][7:0];
			b = regSel[3] ? rf[regSel[2:0]][7:0] : rf[regSel[2:0]][15:8];
			if (m) b = sh[a];
			c = ccrIn[0];
			nb = b;
			nb[bitPos] = c ^ opSel[0];
			if (opSel == 3'h4) c = c & b[bitPos];
			else if (opSel < 3'h2) c = b[bitPos] ^ opSel[0];
			else if (opSel < 3'h4 && m) sh[a] = nb;
			else if (opSel < 3'h4 && regSel[3]) rf[regSel[2:0]][7:0] = nb;
			else if (opSel < 3'h4) rf[regSel[2:0]][15:8] = nb;
			exq.push_back({m ? `BCM_LEN_MEM : `BCM_LEN_REG,
				opSel[2:1] == 2'h1 && m, nb, ccrIn[7:1], c});
			@(posedge clk);
			start <= 1'h0;
			ccrLoad <= 1'h1;
			ccrIn <= ~ccrIn;
			while (done_ff !== 1'h1) @(posedge clk);
		end
		for (int i = 0; i < 8; i++) begin
			@(posedge clk);
			extRdIdx <= i[2:0];
			@(posedge clk);
			@(posedge clk);
			chkReg(rf[i]);
		end
		@(posedge clk);
		give_verdict;
	end
endmodule // bcm_unit_tb
`default_nettype wire
